// ==== design/sleep_ctrl_defs.svh ====
`ifndef SLEEP_CTRL_DEFS_SVH
`define SLEEP_CTRL_DEFS_SVH

// register byte offsets
`define REG_CTRL        12'h000
`define REG_STATUS      12'h004
`define REG_MASK        12'h008
`define REG_WAKE_EN     12'h00c
`define REG_PORT_IN     12'h010
`define REG_MODE        12'h014
`define REG_WDT_CTRL    12'h018
`define REG_RST_STATUS  12'h01c

// control register bits
`define CTRL_OSC_WDT_EN 0
`define CTRL_WDT_EN     1
`define CTRL_WDT_IRQ    2
`define CTRL_BOD_STOP   3
`define CTRL_PERIPH_LSB 8
`define CTRL_RESET      32'h0000_0003

// status / mask bits
`define EV_WAKE         0
`define EV_WDT          1
`define EV_SHORT        2
`define EV_RESET        3
`define EV_W            4

// watchdog control bits
`define WDTC_TIMEOUT    0
`define WDTC_RECOVERY   1

// timing
`define CLK_HZ          40000000
`define RECOVERY_NS     5000
`define MIN_PULSE_NS    100
`define RECOVERY_CYC    ((`RECOVERY_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define MIN_PULSE_CYC   ((`MIN_PULSE_NS * (`CLK_HZ / 1000000) + 999) / 1000)

`endif

// ==== design/sleep_ctrl_pkg.sv ====
`default_nettype none
package sleep_ctrl_pkg;
  // power state
  typedef enum logic [1:0] {
    ST_ACTIVE  = 2'b00,
    ST_IDLE    = 2'b01,
    ST_SLEEP   = 2'b10,
    ST_RECOVER = 2'b11
  } power_state_t;
endpackage : sleep_ctrl_pkg
`default_nettype wire

// ==== design/stop_mode_recovery_control.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sleep_ctrl_defs.svh"

// Operation
// - watchdog reset timeout in sleep recovers instead
// - watchdog interrupt timeout recovers, then interrupts
// - enabled pin level change wakes device
// - reset pin in sleep gives system reset
// - debug pin low in sleep resets
// - sleep timeout sets timeout and recovery flags
// - short wake pulse sets reset-status recovery flag
// - port input frozen, captured after delay
// - sleep instruction stops all but watchdog, and brownout if option set
// - idle state stops only the cpu
// - sleep stops oscillators, clock and cpu
// - sleep releases crystal pins to gpio
// - watchdog oscillator and counter may run
// - brownout runs in sleep if option set
// - active state allows per-peripheral disable
// - other peripherals idle during sleep
// - recovery sets watchdog recovery flag
module stop_mode_recovery_control #(
  parameter int PINS         = 24,
  parameter int PERIPHS      = 8,
  parameter int RECOVERY_CYC = `RECOVERY_CYC,
  parameter int MIN_PULSE    = `MIN_PULSE_CYC
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               srst,
  // axi4-lite write address
  input  wire logic [11:0]        s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  // axi4-lite write response
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  // axi4-lite read address
  input  wire logic [11:0]        s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  // axi4-lite read data
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // cpu side
  input  wire logic               sleep_cmd,
  input  wire logic               idle_cmd,
  input  wire logic               cpu_irq_any,
  input  wire logic               irq_enabled,
  output logic                    cpu_run,
  output logic                    wdt_irq_req,
  // watchdog
  input  wire logic               wdt_timeout,
  // pins
  input  wire logic [PINS-1:0]    gpio_in,
  input  wire logic               reset_pin_n,
  input  wire logic               debug_pin,
  // power and clock controls
  output logic                    system_reset,
  output logic                    primary_osc_en,
  output logic                    precision_osc_en,
  output logic                    system_clk_en,
  output logic                    crystal_input_en,
  output logic                    crystal_output_en,
  output logic                    wdt_osc_en,
  output logic                    wdt_count_en,
  output logic                    brownout_en,
  output logic [PERIPHS-1:0]      periph_en,
  output logic [PINS-1:0]         port_input_data,
  // interrupt
  output logic                    irq
);

  // refuse parameter values the logic cannot serve
  if (PINS < 1 || PINS > 32 || PERIPHS < 1 || PERIPHS > 24 ||
      RECOVERY_CYC < 1 || RECOVERY_CYC > 65535 || MIN_PULSE < 1 ||
      MIN_PULSE > RECOVERY_CYC) begin : g_bad_params
    $error("unsupported parameter values");
  end

  // ==========================================================
  // pin synchronisers
  // ==========================================================
  logic [PINS-1:0] gpio_meta;
  logic [PINS-1:0] gpio_sync;
  logic [PINS-1:0] gpio_prev;
  logic [1:0]      rst_meta;
  logic [1:0]      rst_sync;
  // two flops on every pin input
  always_ff @(posedge clk) begin
    if (srst) begin
      gpio_meta <= '0;
      gpio_sync <= '0;
      gpio_prev <= '0;
      rst_meta  <= 2'h3;
      rst_sync  <= 2'h3;
    end else begin
      gpio_meta <= gpio_in;
      gpio_sync <= gpio_meta;
      gpio_prev <= gpio_sync;
      rst_meta  <= {debug_pin, reset_pin_n};
      rst_sync  <= rst_meta;
    end
  end
  logic reset_pin_low;
  logic debug_low;
  assign reset_pin_low = !rst_sync[0];
  assign debug_low     = !rst_sync[1];
  // ==========================================================
  // registers
  // ==========================================================
  logic [31:0]     ctrl;
  logic [`EV_W-1:0] status;
  logic [`EV_W-1:0] mask;
  logic [PINS-1:0] wake_en;
  logic [1:0]      wdt_ctrl;
  logic            rst_status;
  sleep_ctrl_pkg::power_state_t state;
  logic [15:0]     rec_cnt;
  logic [PINS-1:0] wake_pins;
  logic            wake_from_wdt;
  logic            wdt_irq_pending;
  logic            wr_fire;
  logic            wr_addr_held;
  logic            wr_data_held;
  logic [11:0]     wr_addr;
  logic [31:0]     wr_data;
  logic [3:0]      wr_strb;
  // ==========================================================
  // events
  // ==========================================================
  logic in_sleep;
  logic wake_pin_ev;
  logic wdt_ev;
  logic hard_reset_ev;
  logic short_ev;
  logic rec_done;
  logic [PINS-1:0] pin_change;
  assign in_sleep    = (state == sleep_ctrl_pkg::ST_SLEEP);
  assign pin_change  = (gpio_sync ^ gpio_prev) & wake_en;
  assign wake_pin_ev = in_sleep && |pin_change;
  assign wdt_ev      = in_sleep && wdt_timeout && ctrl[`CTRL_WDT_EN];
  assign hard_reset_ev = reset_pin_low || debug_low;
  assign rec_done = (state == sleep_ctrl_pkg::ST_RECOVER) &&
                    (rec_cnt == 16'(RECOVERY_CYC - 1));
  // pin wake abandoned when the pin returned before the minimum width
  assign short_ev = (state == sleep_ctrl_pkg::ST_RECOVER) && !wake_from_wdt &&
                    (rec_cnt < 16'(MIN_PULSE)) &&
                    |((gpio_sync ^ gpio_prev) & wake_pins);

  // ==========================================================
  // power state machine
  // ==========================================================
  always_ff @(posedge clk) begin
    if (srst || hard_reset_ev) begin
      state <= sleep_ctrl_pkg::ST_ACTIVE;
      rec_cnt <= '0;
      wake_pins <= '0;
      wake_from_wdt <= 1'b0;
    end else begin
      case (state)
        sleep_ctrl_pkg::ST_ACTIVE: begin
          if (sleep_cmd)
            state <= sleep_ctrl_pkg::ST_SLEEP;
          else if (idle_cmd)
            state <= sleep_ctrl_pkg::ST_IDLE;
        end
        sleep_ctrl_pkg::ST_IDLE: begin
          if (cpu_irq_any || wdt_timeout)
            state <= sleep_ctrl_pkg::ST_ACTIVE;
        end
        sleep_ctrl_pkg::ST_SLEEP: begin
          rec_cnt <= '0;
          if (wdt_ev || wake_pin_ev) begin
            state <= sleep_ctrl_pkg::ST_RECOVER;
            wake_from_wdt <= wdt_ev;
            wake_pins <= pin_change;
          end
        end
        sleep_ctrl_pkg::ST_RECOVER: begin
          rec_cnt <= rec_cnt + 16'h0001;
          if (short_ev)
            state <= sleep_ctrl_pkg::ST_SLEEP;
          else if (rec_done)
            state <= sleep_ctrl_pkg::ST_ACTIVE;
        end
        default: state <= sleep_ctrl_pkg::ST_ACTIVE;
      endcase
    end
  end

  // ==========================================================
  // sticky flags
  // ==========================================================
  // watchdog control flags, set by hardware, cleared by writing one
  always_ff @(posedge clk) begin
    if (srst) begin
      wdt_ctrl <= '0;
    end else begin
      if (wr_fire && wr_addr == `REG_WDT_CTRL && wr_strb[0])
        wdt_ctrl <= wdt_ctrl & ~wr_data[1:0];
      if (wdt_ev)
        wdt_ctrl[`WDTC_TIMEOUT] <= 1'b1;
      if (wdt_ev || rec_done)
        wdt_ctrl[`WDTC_RECOVERY] <= 1'b1;
    end
  end
  // reset status recovery flag on an abandoned short pulse
  always_ff @(posedge clk) begin
    if (srst) begin
      rst_status <= 1'b0;
    end else begin
      if (wr_fire && wr_addr == `REG_RST_STATUS && wr_strb[0] && wr_data[0])
        rst_status <= 1'b0;
      if (short_ev)
        rst_status <= 1'b1;
    end
  end
  // interrupt status, set wins over clear
  logic [`EV_W-1:0] ev_vec;
  assign ev_vec = {hard_reset_ev, short_ev, wdt_ev, rec_done};
  always_ff @(posedge clk) begin
    if (srst) begin
      status <= '0;
    end else begin
      if (wr_fire && wr_addr == `REG_STATUS && wr_strb[0])
        status <= (status & ~wr_data[`EV_W-1:0]) | ev_vec;
      else
        status <= status | ev_vec;
    end
  end
  assign irq = |(status & mask);
  // watchdog interrupt held until recovery ends
  always_ff @(posedge clk) begin
    if (srst) begin
      wdt_irq_pending <= 1'b0;
      wdt_irq_req <= 1'b0;
    end else begin
      if (wdt_ev && ctrl[`CTRL_WDT_IRQ])
        wdt_irq_pending <= 1'b1;
      else if (rec_done)
        wdt_irq_pending <= 1'b0;
      wdt_irq_req <= rec_done && wdt_irq_pending && irq_enabled;
    end
  end

  // ==========================================================
  // port input capture
  // ==========================================================
  // frozen in sleep; updated once level survives the delay
  always_ff @(posedge clk) begin
    if (srst)
      port_input_data <= '0;
    else if (state == sleep_ctrl_pkg::ST_ACTIVE ||
             state == sleep_ctrl_pkg::ST_IDLE || rec_done)
      port_input_data <= gpio_sync;
  end

  // ==========================================================
  // clock and power outputs
  // ==========================================================
  // clocks, oscillators and peripherals follow the power state
  always_ff @(posedge clk) begin
    if (srst) begin
      system_reset      <= 1'b1;
      primary_osc_en    <= 1'b0;
      precision_osc_en  <= 1'b0;
      system_clk_en     <= 1'b0;
      crystal_input_en  <= 1'b0;
      crystal_output_en <= 1'b0;
      cpu_run           <= 1'b0;
      periph_en         <= '0;
      wdt_osc_en        <= 1'b0;
      wdt_count_en      <= 1'b0;
      brownout_en       <= 1'b1;
    end else begin
      system_reset      <= hard_reset_ev;
      primary_osc_en    <= !in_sleep;
      precision_osc_en  <= !in_sleep;
      system_clk_en     <= !in_sleep;
      crystal_input_en  <= !in_sleep;
      crystal_output_en <= !in_sleep;
      cpu_run <= (state == sleep_ctrl_pkg::ST_ACTIVE) && !sleep_cmd &&
                 !idle_cmd;
      // peripherals off in sleep and recovery, per-bit control in active and idle
      periph_en <= (in_sleep || state == sleep_ctrl_pkg::ST_RECOVER) ? '0 :
                   ctrl[`CTRL_PERIPH_LSB +: PERIPHS];
      wdt_osc_en   <= ctrl[`CTRL_OSC_WDT_EN];
      wdt_count_en <= ctrl[`CTRL_WDT_EN];
      brownout_en  <= !in_sleep || ctrl[`CTRL_BOD_STOP];
    end
  end

  // ==========================================================
  // axi4-lite write channel
  // ==========================================================
  assign s_axi_awready = !wr_addr_held && !s_axi_bvalid;
  assign s_axi_wready  = !wr_data_held && !s_axi_bvalid;
  assign s_axi_bresp   = 2'h0;
  assign wr_fire       = wr_addr_held && wr_data_held && !s_axi_bvalid;
  // address and data may come in either order
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_addr_held <= 1'b0;
      wr_data_held <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        wr_addr_held <= 1'b1;
        wr_addr <= {s_axi_awaddr[11:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wr_data_held <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        wr_addr_held <= 1'b0;
        wr_data_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
  // plain read-write registers with byte enables
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl <= `CTRL_RESET;
      mask <= '0;
      wake_en <= '0;
    end else if (wr_fire) begin
      for (int b = 0; b < 4; b++) begin
        if (wr_strb[b]) begin
          if (wr_addr == `REG_CTRL)
            ctrl[b*8 +: 8] <= wr_data[b*8 +: 8];
          if (wr_addr == `REG_WAKE_EN) begin
            for (int i = 0; i < 8; i++)
              if (b*8 + i < PINS)
                wake_en[b*8 + i] <= wr_data[b*8 + i];
          end
        end
      end
      if (wr_addr == `REG_MASK && wr_strb[0])
        mask <= wr_data[`EV_W-1:0];
    end
  end

  // ==========================================================
  // axi4-lite read channel
  // ==========================================================
  logic [31:0] rd_mux;
  logic        rd_ok;
  always_comb begin
    rd_mux = '0;
    rd_ok  = 1'b1;
    case ({s_axi_araddr[11:2], 2'h0})
      `REG_CTRL:       rd_mux = ctrl;
      `REG_STATUS:     rd_mux[`EV_W-1:0] = status;
      `REG_MASK:       rd_mux[`EV_W-1:0] = mask;
      `REG_WAKE_EN:    rd_mux[PINS-1:0] = wake_en;
      `REG_PORT_IN:    rd_mux[PINS-1:0] = port_input_data;
      `REG_MODE:       rd_mux[1:0] = state;
      `REG_WDT_CTRL:   rd_mux[1:0] = wdt_ctrl;
      `REG_RST_STATUS: rd_mux[0] = rst_status;
      default:         rd_ok = 1'b0;
    endcase
  end
  assign s_axi_arready = !s_axi_rvalid;
  // read answer registered one cycle after the address is taken
  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? 2'h0 : 2'h2; // slverr when unmapped
    end else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule : stop_mode_recovery_control
`default_nettype wire

// ==== bench/sleep_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// power state checker
module sleep_checker #(
  parameter int PINS         = 24,
  parameter int PERIPHS      = 8,
  parameter int RECOVERY_CYC = 8
) (
  // clock and reset
  input wire logic               clk,
  input wire logic               srst,
  // cpu and pins
  input wire logic               sleep_cmd,
  input wire logic               irq_enabled,
  input wire logic               reset_pin_n,
  input wire logic               debug_pin,
  input wire logic               cpu_run,
  input wire logic               wdt_irq_req,
  // power controls
  input wire logic               system_reset,
  input wire logic               primary_osc_en,
  input wire logic               precision_osc_en,
  input wire logic               system_clk_en,
  input wire logic               crystal_input_en,
  input wire logic               crystal_output_en,
  input wire logic               brownout_en,
  input wire logic [PERIPHS-1:0] periph_en,
  input wire logic [PINS-1:0]    port_input_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  int   awake_cnt;
  logic woke;
  // cycles with the clock back on, and whether a sleep preceded them
  always_ff @(posedge clk) begin
    if (srst || system_reset) begin
      awake_cnt <= 0;
      woke      <= 1'b0;
    end else begin
      awake_cnt <= system_clk_en ? awake_cnt + 1 : 0;
      if (!system_clk_en)
        woke <= 1'b1;
      else if (cpu_run)
        woke <= 1'b0;
    end
  end
  // ==========================================
  // assertions
  a_sleep_clk_stop: assert property (sleep_cmd && cpu_run && !system_reset
    |-> ##[1:3] !system_clk_en) else $error("sleep did not stop clock");
  a_osc_group: assert property ((primary_osc_en == system_clk_en) &&
    (precision_osc_en == system_clk_en) && (crystal_input_en == system_clk_en)
    && (crystal_output_en == system_clk_en)) else $error("osc enables split");
  a_cpu_halt: assert property (!system_clk_en |-> !cpu_run)
    else $error("cpu runs without clock");
  a_periph_idle: assert property (!system_clk_en |-> periph_en == '0)
    else $error("peripheral on in sleep");
  a_bod_active: assert property (system_clk_en |-> brownout_en)
    else $error("brownout off while awake");
  a_port_frozen: assert property (!system_clk_en && !system_reset
    |=> $stable(port_input_data)) else $error("port input moved in sleep");
  a_reset_pin: assert property (!reset_pin_n [*4] |-> system_reset)
    else $error("reset pin ignored");
  a_debug_pin: assert property (!debug_pin [*4] |-> system_reset)
    else $error("debug pin ignored");
  a_recovery_hold: assert property ($rose(cpu_run) && woke && !system_reset
    |-> awake_cnt >= RECOVERY_CYC - 1) else $error("cpu released early");
  a_wdt_irq_once: assert property (wdt_irq_req
    |-> irq_enabled ##1 !wdt_irq_req) else $error("bad watchdog irq");
  c_sleep: cover property (sleep_cmd && cpu_run);
  c_wake: cover property ($rose(cpu_run) && woke);
  c_wdt_irq: cover property (wdt_irq_req);
endmodule : sleep_checker
`default_nettype wire

// ==== bench/wdt_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// watchdog counter standing beside the block
module wdt_model #(
  parameter int LIMIT = 30
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic count_en,
  input wire logic arm,
  output logic     timeout
);
  int cnt;
  // counts only while the block lets the watchdog run; one pulse per arm
  always_ff @(posedge clk) begin
    if (srst || !arm) begin
      cnt     <= 0;
      timeout <= 1'b0;
    end else if (count_en) begin
      cnt     <= cnt + 1;
      timeout <= (cnt == LIMIT - 1);
    end
  end
endmodule : wdt_model
`default_nettype wire

// ==== bench/tb_stop_mode_recovery_control.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sleep_ctrl_defs.svh"
// ==========================================
// testbench
module tb_stop_mode_recovery_control;
  localparam int RC = 8;
  logic        clk = 0, srst = 1, awv = 0, wv = 0, bready = 0, arv = 0;
  logic        rready = 0, slp = 0, idl = 0, irq_any = 0, irq_en = 0;
  logic        arm = 0, rst_n = 1, dbg = 1, wdt_to, awr, wrdy, bv, arr, rv;
  logic        run, wirq, sysrst, pos, pcs, sce, xi, xo, wos, wce, bod, irq;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, got;
  logic [1:0]  bresp, rresp, gresp;
  logic [23:0] gpio = '0, pin_q;
  logic [7:0]  per;
  int          bad_count = 0, checked = 0, npulse = 0, nrst = 0, n0, r0;
  always #12.5 clk = ~clk;
  stop_mode_recovery_control #(.RECOVERY_CYC(RC), .MIN_PULSE(2)) uut (
    .clk(clk), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready),
    .sleep_cmd(slp), .idle_cmd(idl), .cpu_irq_any(irq_any),
    .irq_enabled(irq_en), .cpu_run(run), .wdt_irq_req(wirq),
    .wdt_timeout(wdt_to), .gpio_in(gpio), .reset_pin_n(rst_n),
    .debug_pin(dbg), .system_reset(sysrst), .primary_osc_en(pos),
    .precision_osc_en(pcs), .system_clk_en(sce), .crystal_input_en(xi),
    .crystal_output_en(xo), .wdt_osc_en(wos), .wdt_count_en(wce),
    .brownout_en(bod), .periph_en(per), .port_input_data(pin_q), .irq(irq));
  wdt_model #(.LIMIT(30)) wdm (.clk(clk), .srst(srst), .count_en(wce),
    .arm(arm), .timeout(wdt_to));
  // counts watchdog irq pulses and reset cycles
  always @(posedge clk) begin
    if (wirq) npulse++;
    if (sysrst && !srst) nrst++;
  end
  // ==========================================
  // tasks
  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    int   n;
    @(posedge clk);
    awaddr <= a;
    wdata  <= d;
    awv    <= 1;
    wv     <= 1;
    bready <= 1;
    n = 0;
    bh = 0;
    while (!bh && n < 100) begin
      @(negedge clk);
      ah = awv & awr;
      wh = wv & wrdy;
      bh = bv;
      @(posedge clk);
      if (ah) awv <= 0;
      if (wh) wv <= 0;
      n++;
    end
    bready <= 0;
    chk(bh, 1, "write hang");
    chk(bresp, 2'h0, "write resp");
  endtask : wr
  task rd(input logic [11:0] a);
    logic ah, rh;
    int   n;
    @(posedge clk);
    araddr <= a;
    arv    <= 1;
    rready <= 1;
    n = 0;
    rh = 0;
    while (!rh && n < 100) begin
      @(negedge clk);
      ah = arv & arr;
      rh = rv;
      got = rdata;
      gresp = rresp;
      @(posedge clk);
      if (ah) arv <= 0;
      n++;
    end
    rready <= 0;
    chk(rh, 1, "read hang");
  endtask : rd
  task rchk(input logic [11:0] a, input logic [31:0] e, input string m);
    rd(a);
    chk(gresp, 2'h0, "read resp");
    chk(got, e, m);
  endtask : rchk
  task wait_run;
    int n;
    n = 0;
    @(negedge clk);
    while (!run && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk(run, 1, "no wake");
  endtask : wait_run
  task go_sleep;
    @(posedge clk) slp <= 1;
    @(posedge clk) slp <= 0;
    repeat (4) @(posedge clk);
  endtask : go_sleep
  task give_verdict;
    $display("mismatches %0d comparisons %0d", bad_count, checked);
    if (bad_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  // ==========================================
  // tests
  initial begin
    repeat (10) @(posedge clk);
    srst <= 0;
    repeat (4) @(posedge clk);
    rchk(`REG_CTRL, `CTRL_RESET, "ctrl reset");
    rchk(`REG_MODE, 0, "mode reset");
    rd(12'h0f0);
    chk(gresp, 2'h2, "unmapped");
    chk({wos, wce}, 2'h3, "wdt runs");
    wr(`REG_MASK, 32'hf);
    wr(`REG_WAKE_EN, 32'h20);
    wr(`REG_CTRL, 32'h0000_a503);
    @(negedge clk);
    chk(per, 8'ha5, "periph enables");
    @(posedge clk) idl <= 1;
    @(posedge clk) idl <= 0;
    repeat (3) @(negedge clk);
    chk({run, sce, per}, {2'b01, 8'ha5}, "idle outs");
    rchk(`REG_MODE, 1, "mode idle");
    @(posedge clk) irq_any <= 1;
    wait_run;
    @(posedge clk) irq_any <= 0;
    for (int v = 1; v >= 0; v--) begin
      go_sleep;
      chk({sce, pos, pcs, xi, xo, per, bod, wos, wce}, 16'h3,
          "sleep outs");
      rchk(`REG_MODE, 2, "mode sleep");
      @(posedge clk) gpio[3] <= v[0];
      repeat (8) @(posedge clk);
      rchk(`REG_MODE, 2, "masked pin");
      @(posedge clk) gpio[5] <= v[0];
      wait_run;
      chk(pin_q[5], v[0], "port capture");
      rchk(`REG_WDT_CTRL, 2, "recovery flag");
      rchk(`REG_STATUS, 1, "status wake");
      chk(irq, 1, "irq raised");
      wr(`REG_MASK, 0);
      chk(irq, 0, "irq masked");
      wr(`REG_MASK, 32'hf);
      wr(`REG_STATUS, 32'hf);
      wr(`REG_WDT_CTRL, 3);
      chk(irq, 0, "irq cleared");
    end
    go_sleep;
    @(posedge clk) gpio[5] <= 1;
    @(posedge clk) gpio[5] <= 0;
    repeat (30) @(posedge clk);
    rchk(`REG_MODE, 2, "short pulse");
    rchk(`REG_RST_STATUS, 1, "short flag");
    chk(pin_q[5], 0, "port unchanged");
    wr(`REG_STATUS, 32'hf);
    wr(`REG_RST_STATUS, 1);
    for (int m = 0; m < 2; m++) begin
      if (m == 1) begin
        wr(`REG_CTRL, 32'h0000_a50f);
        irq_en <= 1;
        go_sleep;
      end
      chk(bod, m[0], "bod option");
      n0 = npulse;
      r0 = nrst;
      @(posedge clk) arm <= 1;
      wait_run;
      @(posedge clk) arm <= 0;
      repeat (5) @(posedge clk);
      rchk(`REG_WDT_CTRL, 3, "wdt flags");
      rchk(`REG_STATUS, 3, "status wdt");
      chk(npulse - n0, m, "wdt irq");
      chk(nrst - r0, 0, "no reset");
      wr(`REG_STATUS, 32'hf);
      wr(`REG_WDT_CTRL, 3);
    end
    for (int k = 0; k < 2; k++) begin
      go_sleep;
      r0 = nrst;
      @(posedge clk);
      if (k == 0) rst_n <= 0;
      else dbg <= 0;
      repeat (6) @(posedge clk);
      rst_n <= 1;
      dbg <= 1;
      repeat (4) @(posedge clk);
      chk(nrst > r0, 1, "pin reset");
      rchk(`REG_MODE, 0, "reset mode");
      rd(`REG_STATUS);
      chk(got[3], 1, "reset status");
      wr(`REG_STATUS, 32'hf);
      wait_run;
    end
    give_verdict;
  end
  // cuts a hang short
  initial begin
    #1000000;
    bad_count++;
    give_verdict;
  end
endmodule : tb_stop_mode_recovery_control
bind stop_mode_recovery_control sleep_checker #(.PINS(PINS),
  .PERIPHS(PERIPHS), .RECOVERY_CYC(RECOVERY_CYC)) chk_i (.clk(clk),
  .srst(srst), .sleep_cmd(sleep_cmd), .irq_enabled(irq_enabled),
  .reset_pin_n(reset_pin_n), .debug_pin(debug_pin), .cpu_run(cpu_run),
  .wdt_irq_req(wdt_irq_req), .system_reset(system_reset),
  .primary_osc_en(primary_osc_en), .precision_osc_en(precision_osc_en),
  .system_clk_en(system_clk_en), .crystal_input_en(crystal_input_en),
  .crystal_output_en(crystal_output_en), .brownout_en(brownout_en),
  .periph_en(periph_en), .port_input_data(port_input_data));
`default_nettype wire
